// file: hw/iorc_ctrl.sv
// User-side recalibration controller: APB registers drive the bank handshake.
// Assumes an APB master on pclk and the engine on the same clock.
`timescale 1ns/1ps
`default_nettype none
module iorc_ctrl
	import iorc_pkg::*;
#(
	parameter int NUM_IO = IORC_NUM_IO
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic [NUM_IO-1:0] lane_sel,
	iorc_if.usr link
);
	logic wr, rd, hit;
	logic auto_apply, next_auto_apply;
	logic apply_req, next_apply_req;
	logic busy, next_busy;
	logic start, next_start;
	logic done_q, next_done_q;
	logic [1:0] int_stat, next_int_stat;
	logic [1:0] int_mask, next_int_mask;
	logic [NUM_IO-1:0] next_lane_sel;
	logic [31:0] next_prdata;
	logic [31:0] rd_mux;

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign hit = paddr == IORC_OFF_CTRL || paddr == IORC_OFF_STATUS ||
		paddr == IORC_OFF_INT_STAT || paddr == IORC_OFF_INT_MASK ||
		paddr == IORC_OFF_LANE_SEL;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign irq = |(int_stat & int_mask);

	assign link.cal_start = start;
	assign link.cal_lock = (apply_req | auto_apply) & link.cal_code_ready;
	assign link.cal_load = 1'b1;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			IORC_OFF_CTRL: rd_mux[IORC_CTRL_AUTO] = auto_apply;
			IORC_OFF_STATUS:
			begin
				rd_mux[IORC_ST_DONE] = link.cal_status;
				rd_mux[IORC_ST_READY] = link.cal_code_ready;
				rd_mux[IORC_ST_APPLY] = apply_req;
				rd_mux[IORC_ST_BUSY] = busy;
			end
			IORC_OFF_INT_STAT: rd_mux[1:0] = int_stat;
			IORC_OFF_INT_MASK: rd_mux[1:0] = int_mask;
			IORC_OFF_LANE_SEL: rd_mux[NUM_IO-1:0] = lane_sel;
			default: rd_mux = 32'h0000_0000;
		endcase
		// Read data is captured in the setup cycle so it stands during access
		next_prdata = (psel && !penable && !pwrite) ? rd_mux : prdata;
		next_auto_apply = auto_apply;
		next_apply_req = apply_req;
		next_busy = busy;
		next_start = 1'b0;
		next_done_q = link.cal_status;
		next_int_mask = int_mask;
		next_lane_sel = lane_sel;
		next_int_stat = int_stat;
		if (rd && paddr == IORC_OFF_INT_STAT)
		begin
			// A read clears only the bits it reported
			next_int_stat = int_stat & ~prdata[1:0];
		end
		if (link.cal_status && !done_q)
		begin
			next_busy = 1'b0;
		end
		if (wr && paddr == IORC_OFF_CTRL)
		begin
			next_auto_apply = pwdata[IORC_CTRL_AUTO];
			if (pwdata[IORC_CTRL_START] && !busy)
			begin
				next_start = 1'b1;
				next_busy = 1'b1;
				next_apply_req = 1'b0;
			end
			if (pwdata[IORC_CTRL_APPLY] && (busy || pwdata[IORC_CTRL_START]))
			begin
				next_apply_req = 1'b1;
			end
		end
		if (wr && paddr == IORC_OFF_INT_MASK)
		begin
			next_int_mask = pwdata[1:0];
		end
		if (wr && paddr == IORC_OFF_LANE_SEL)
		begin
			// Clocks and resets should be opted out to avoid glitches
			next_lane_sel = pwdata[NUM_IO-1:0];
		end
		if (link.cal_lock)
		begin
			next_apply_req = 1'b0;
		end
		// Set wins over the read clear
		if (link.io_code_ready_pulse)
		begin
			next_int_stat[IORC_INT_READY] = 1'b1;
		end
		if (link.cal_status && !done_q)
		begin
			next_int_stat[IORC_INT_DONE] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= IORC_REG_RST;
			auto_apply <= 1'b0;
			apply_req <= 1'b0;
			busy <= 1'b0;
			start <= 1'b0;
			done_q <= 1'b0;
			int_stat <= IORC_INT_RST;
			int_mask <= IORC_INT_RST;
			lane_sel <= '0;
		end
		else
		begin
			prdata <= next_prdata;
			auto_apply <= next_auto_apply;
			apply_req <= next_apply_req;
			busy <= next_busy;
			start <= next_start;
			done_q <= next_done_q;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			lane_sel <= next_lane_sel;
		end
	end
endmodule : iorc_ctrl
`default_nettype wire

// file: hw/iorc_engine.sv
// Bank calibration engine: runs calibration, holds new codes, applies on request.
// Assumes handshake inputs on pclk; meas_code arrives from the analog side.
`timescale 1ns/1ps
`default_nettype none
module iorc_engine
	import iorc_pkg::*;
#(
	parameter bit RECAL_EN = 1'b1,
	parameter int CODE_W = IORC_CODE_W,
	parameter int NUM_IO = IORC_NUM_IO,
	parameter int CAL_CYCLES = IORC_CAL_CYCLES
)(
	input wire logic pclk,
	input wire logic presetn,
	iorc_if.dev link,
	input wire logic init_cal_en,
	input wire logic [CODE_W-1:0] meas_code,
	input wire logic [NUM_IO-1:0] lane_sel,
	output logic [NUM_IO*CODE_W-1:0] io_code,
	output logic [CODE_W-1:0] lane_code
);
	typedef enum logic [4:0] {
		ST_INIT = 5'b00001,
		ST_IDLE = 5'b00010,
		ST_RUN = 5'b00100,
		ST_PEND = 5'b01000,
		ST_LATCH = 5'b10000
	} iorc_state_t;

	localparam int CNT_W = $clog2(CAL_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CAL_CYCLES - 1);
	localparam logic [CODE_W-1:0] CODE_RST = CODE_W'(IORC_CODE_RST);

	// True on the last counting cycle of a calibration run
	function automatic logic run_end(input logic [CNT_W-1:0] c);
		return c == CNT_LAST;
	endfunction : run_end

	iorc_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [CODE_W-1:0] meas_s1, meas_s2;
	logic [CODE_W-1:0] pend_code, next_pend_code;
	logic [CODE_W-1:0] bank_code, next_bank_code;
	logic [CODE_W-1:0] init_code, next_init_code;
	logic [CODE_W-1:0] next_lane_code;
	logic [NUM_IO*CODE_W-1:0] next_io_code;
	logic init_done, next_init_done;
	logic status, next_status;
	logic ready, next_ready;
	logic pulse, next_pulse;
	logic start_in, lock_in, load_in;

	// With recalibration off the user handshake is ignored entirely
	assign start_in = RECAL_EN & link.cal_start;
	assign lock_in = RECAL_EN & link.cal_lock;
	assign load_in = link.cal_load | ~RECAL_EN;

	assign link.cal_status = RECAL_EN & status;
	assign link.cal_code_ready = RECAL_EN & ready;
	assign link.io_code_ready_pulse = RECAL_EN & pulse;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_pend_code = pend_code;
		next_bank_code = bank_code;
		next_init_code = init_code;
		next_lane_code = lane_code;
		next_init_done = init_done;
		next_status = status;
		next_ready = ready;
		next_pulse = 1'b0;
		next_io_code = io_code;
		unique case (state)
			ST_INIT:
			begin
				next_cnt = cnt + CNT_W'(1);
				if (run_end(cnt))
				begin
					next_pend_code = meas_s2;
					next_pulse = 1'b1;
					next_ready = 1'b1;
					next_state = ST_LATCH;
				end
			end
			ST_IDLE:
			begin
				if (start_in)
				begin
					next_status = 1'b0;
					next_cnt = '0;
					next_state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				next_cnt = cnt + CNT_W'(1);
				if (lock_in)
				begin
					next_pend_code = meas_s2;
					next_state = ST_LATCH;
				end
				else if (run_end(cnt))
				begin
					next_pend_code = meas_s2;
					next_pulse = 1'b1;
					next_ready = 1'b1;
					next_state = ST_PEND;
				end
			end
			ST_PEND:
			begin
				if (lock_in)
				begin
					next_state = ST_LATCH;
				end
				else if (start_in)
				begin
					next_ready = 1'b0;
					next_cnt = '0;
					next_state = ST_RUN;
				end
			end
			ST_LATCH:
			begin
				next_bank_code = pend_code;
				next_ready = 1'b0;
				next_status = 1'b1;
				if (!init_done)
				begin
					next_init_code = pend_code;
					next_lane_code = pend_code;
					next_init_done = 1'b1;
				end
				next_state = ST_IDLE;
			end
		endcase
		if (!load_in && state != ST_LATCH && init_done)
		begin
			next_bank_code = init_code;
		end
		for (int i = 0; i < NUM_IO; i++)
		begin
			// Opted-out lanes keep the frozen copy from the first run while init_cal_en is high
			next_io_code[i*CODE_W +: CODE_W] =
				(lane_sel[i] && init_cal_en) ? next_lane_code : next_bank_code;
		end
	end

	// Two-flop synchroniser; the word must be quasi-static as bits may skew
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meas_s1 <= CODE_RST;
			meas_s2 <= CODE_RST;
		end
		else
		begin
			meas_s1 <= meas_code;
			meas_s2 <= meas_s1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_INIT;
			cnt <= '0;
			pend_code <= CODE_RST;
			bank_code <= CODE_RST;
			init_code <= CODE_RST;
			lane_code <= CODE_RST;
			io_code <= {NUM_IO{CODE_RST}};
			init_done <= 1'b0;
			status <= 1'b0;
			ready <= 1'b0;
			pulse <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			pend_code <= next_pend_code;
			bank_code <= next_bank_code;
			init_code <= next_init_code;
			lane_code <= next_lane_code;
			io_code <= next_io_code;
			init_done <= next_init_done;
			status <= next_status;
			ready <= next_ready;
			pulse <= next_pulse;
		end
	end
endmodule : iorc_engine
`default_nettype wire

// file: pkg/iorc_if.sv
// Per-bank recalibration handshake between the calibration engine and user logic.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
`default_nettype none
interface iorc_if;
	logic cal_start;
	logic cal_lock;
	logic cal_load;
	logic cal_status;
	logic cal_code_ready;
	logic io_code_ready_pulse;
	modport dev (
		input cal_start,
		input cal_lock,
		input cal_load,
		output cal_status,
		output cal_code_ready,
		output io_code_ready_pulse
	);
	modport usr (
		output cal_start,
		output cal_lock,
		output cal_load,
		input cal_status,
		input cal_code_ready,
		input io_code_ready_pulse
	);
endinterface : iorc_if
`default_nettype wire

// file: pkg/iorc_pkg.sv
// Shared constants for the bank recalibration handshake and its controller.
// Assumes one clock domain (pclk) for both ends.
package iorc_pkg;
	localparam int IORC_CODE_W = 7;
	localparam int IORC_NUM_IO = 8;
	localparam int IORC_CAL_CYCLES = 64;
	localparam logic [IORC_CODE_W-1:0] IORC_CODE_RST = 7'h40;
	// Controller register byte offsets
	localparam logic [7:0] IORC_OFF_CTRL = 8'h00;
	localparam logic [7:0] IORC_OFF_STATUS = 8'h04;
	localparam logic [7:0] IORC_OFF_INT_STAT = 8'h08;
	localparam logic [7:0] IORC_OFF_INT_MASK = 8'h0C;
	localparam logic [7:0] IORC_OFF_LANE_SEL = 8'h10;
	// CTRL fields
	localparam int IORC_CTRL_START = 0;
	localparam int IORC_CTRL_APPLY = 1;
	localparam int IORC_CTRL_AUTO = 2;
	// STATUS fields
	localparam int IORC_ST_DONE = 0;
	localparam int IORC_ST_READY = 1;
	localparam int IORC_ST_APPLY = 2;
	localparam int IORC_ST_BUSY = 3;
	// Interrupt fields
	localparam int IORC_INT_READY = 0;
	localparam int IORC_INT_DONE = 1;
	localparam logic [1:0] IORC_INT_RST = 2'h0;
	localparam logic [31:0] IORC_REG_RST = 32'h0000_0000;
endpackage : iorc_pkg

// file: tb/iorc_asserts.sv
// Checker for the bank recalibration handshake signals.
// Assumes both ends on pclk, presetn asynchronous and active low.
`timescale 1ns/1ps
`default_nettype none
module iorc_asserts #(
	parameter int CAL_CYCLES = 64
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cal_start,
	input wire logic cal_lock,
	input wire logic cal_load,
	input wire logic cal_status,
	input wire logic cal_code_ready,
	input wire logic io_code_ready_pulse
);
	localparam int RUN_MAX = CAL_CYCLES + 3;
	logic first_run;
	logic next_first_run;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// High until the reset-time run has locked
	always_comb next_first_run = first_run & ~cal_status;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			first_run <= 1'b1;
		else
			first_run <= next_first_run;
	property p_first_done;
		first_run && cal_code_ready |=> cal_status;
	endproperty
	a_first_done: assert property (p_first_done) else $error("late first done");
	property p_done_holds;
		cal_status && !cal_start |=> cal_status;
	endproperty
	a_done_holds: assert property (p_done_holds) else $error("done dropped");
	property p_pulse;
		io_code_ready_pulse |-> cal_code_ready ##1 !io_code_ready_pulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("bad ready pulse");
	property p_start;
		cal_start && cal_status |=> !cal_status;
	endproperty
	a_start: assert property (p_start) else $error("start ignored");
	property p_hold;
		!first_run && cal_code_ready && !cal_lock && !$past(cal_lock) && !cal_start
			|=> cal_code_ready;
	endproperty
	a_hold: assert property (p_hold) else $error("pending code lost");
	property p_lock;
		cal_lock |-> ##[1:2] cal_status;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not done");
	property p_run;
		$fell(cal_status) |-> ##[1:RUN_MAX] cal_code_ready;
	endproperty
	a_run: assert property (p_run) else $error("run too long");
	property p_load;
		cal_load;
	endproperty
	a_load: assert property (p_load) else $error("load low");
	property p_lock_rdy;
		cal_lock |-> cal_code_ready;
	endproperty
	a_lock_rdy: assert property (p_lock_rdy) else $error("early lock");
endmodule : iorc_asserts
`default_nettype wire

// file: tb/iorc_tb_top.sv
// Testbench: APB controller and engine joined by the handshake interface.
// Assumes a short calibration count of 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module iorc_tb_top
	import iorc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [6:0] meas_code = 7'h2A;
	logic init_cal_en = 1'b1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [7:0] lane_sel;
	logic [55:0] io_code;
	logic [6:0] lane_code;
	int mismatches = 0;
	int compares = 0;
	iorc_if lnk();
	iorc_engine #(.CAL_CYCLES(4)) i_iorc_engine (.pclk(pclk), .presetn(presetn),
		.link(lnk.dev), .init_cal_en(init_cal_en), .meas_code(meas_code), .lane_sel(lane_sel),
		.io_code(io_code), .lane_code(lane_code));
	iorc_ctrl i_iorc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .lane_sel(lane_sel), .link(lnk.usr));
	iorc_asserts #(.CAL_CYCLES(4)) i_iorc_asserts (.pclk(pclk), .presetn(presetn),
		.cal_start(lnk.cal_start), .cal_lock(lnk.cal_lock), .cal_load(lnk.cal_load),
		.cal_status(lnk.cal_status), .cal_code_ready(lnk.cal_code_ready),
		.io_code_ready_pulse(lnk.io_code_ready_pulse));
	always #25 pclk = ~pclk;
	function automatic logic [6:0] lane(input int i);
		return io_code[i*IORC_CODE_W +: IORC_CODE_W];
	endfunction : lane
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task automatic final_report();
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// One APB transfer; read data and error are taken at the access edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		e = pslverr;
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_st(input int b, output logic [31:0] r);
		logic e;
		int n;
		n = 0;
		do
		begin
			apb(1'b0, IORC_OFF_STATUS, 32'h0, r, e);
			n++;
		end
		while (r[b] !== 1'b1 && n < 40);
		chk(r[b] === 1'b1, "status wait");
	endtask : wait_st
	task automatic t_init();
		logic [31:0] r;
		logic e;
		wait_st(IORC_ST_DONE, r);
		chk(lane(0) === 7'h2A && lane(7) === 7'h2A, "init code");
		chk(lane_code === 7'h2A, "lane copy");
		apb(1'b0, IORC_OFF_INT_STAT, 32'h0, r, e);
		chk(r[1:0] === 2'h3 && irq === 1'b0, "init events");
		apb(1'b0, IORC_OFF_INT_STAT, 32'h0, r, e);
		chk(r[1:0] === 2'h0, "read clear");
	endtask : t_init
	task automatic t_recal();
		logic [31:0] r;
		logic e;
		meas_code <= 7'h15;
		apb(1'b1, IORC_OFF_LANE_SEL, 32'h1, r, e);
		apb(1'b1, IORC_OFF_CTRL, 32'h1, r, e);
		wait_st(IORC_ST_READY, r);
		chk(r[IORC_ST_DONE] === 1'b0 && lane(1) === 7'h2A, "held");
		apb(1'b1, IORC_OFF_INT_MASK, 32'h1, r, e);
		chk(irq === 1'b1, "irq set");
		apb(1'b1, IORC_OFF_CTRL, 32'h2, r, e);
		wait_st(IORC_ST_DONE, r);
		chk(lane(1) === 7'h15 && lane(7) === 7'h15, "applied");
		chk(lane(0) === 7'h2A && lane_code === 7'h2A, "opt out");
		apb(1'b0, IORC_OFF_INT_STAT, 32'h0, r, e);
		chk(r[1:0] === 2'h3 && irq === 1'b0, "irq clear");
	endtask : t_recal
	task automatic t_auto();
		logic [31:0] r;
		logic e;
		int n;
		meas_code <= 7'h33;
		apb(1'b1, IORC_OFF_CTRL, 32'h5, r, e);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (lane(1) !== 7'h33 && n < 40);
		wait_st(IORC_ST_DONE, r);
		chk(lane(1) === 7'h33 && lane(0) === 7'h2A, "auto apply");
	endtask : t_auto
	task automatic t_lane_en();
		init_cal_en <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(lane(0) === 7'h33 && lane_code === 7'h2A, "lane code without init cal");
		init_cal_en <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(lane(0) === 7'h2A, "lane code back");
	endtask : t_lane_en
	task automatic t_unmapped();
		logic [31:0] r;
		logic e;
		apb(1'b1, 8'h20, 32'h1, r, e);
		chk(e === 1'b1, "no slverr");
		apb(1'b0, IORC_OFF_STATUS, 32'h0, r, e);
		chk(r[IORC_ST_DONE] === 1'b1 && e === 1'b0, "status moved");
	endtask : t_unmapped
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_init();
		t_recal();
		t_auto();
		t_lane_en();
		t_unmapped();
		final_report();
	end
	initial
	begin
		repeat (4000) @(posedge pclk);
		mismatches++;
		final_report();
	end
endmodule : iorc_tb_top
`default_nettype wire
